// >>> logic/memory_ref_address_unit.sv
`timescale 1ns/100ps
module memory_ref_address_unit (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // avalon-mm slave
  input  wire logic [4:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // main memory read port, word addressed
  output logic                       memRead,
  output logic      [14:0]           memAddr,
  input  wire logic [15:0]           memRdata,
  input  wire logic                  memValid
);
  import mref_pkg::*;

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,  // waiting for an instruction
    S_PTR  = 3'b010,  // pointer fetch outstanding
    S_OPND = 3'b100   // operand fetch outstanding
  } state_t;

  state_t      state_q;                  // sequencer
  instr_t      instr_q;                  // instruction in flight
  logic        byteOp_q;                 // this instruction uses byte addresses
  logic        byteMode_q;               // established mode
  logic [7:0]  forceCnt_q;               // instructions left under timed force
  logic [15:0] pc_q, x_q, acc_q;         // software visible registers
  logic [15:0] ea_q;                     // effective address
  logic [15:0] opnd_q;                   // operand fetched
  logic        ovf_q;                    // overflow_flag
  logic        wait_q;                   // bus answer pacing
  logic [31:0] rdata_q;                  // bus read data
  logic        memRead_q;                // memory request
  logic [14:0] memAddr_q;                // memory word address

  // bus decode
  logic        acc_go;                   // access takes effect this edge
  logic        wrInstr, wrStat;          // register write strokes
  logic [15:0] wmask;                    // byte lanes of the low half
  assign acc_go  = (read | write) & ~wait_q;
  assign wrInstr = acc_go & write & (address == REG_INSTR);
  assign wrStat  = acc_go & write & (address == REG_STATUS);
  assign wmask   = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // decode of a freshly written instruction
  instr_t      newI;                     // written descriptor
  logic        isMode;                   // mode control, no memory
  logic        isScan;                   // scan forces postindexed addressing
  logic        byteNew;                  // byte address kind for it
  logic        start;                    // accepted only when idle
  amode_t      am;                       // addressing after scan override
  logic        rel;                      // P-relative after override
  assign newI    = instr_t'(writedata[15:0]);
  assign start   = wrInstr & (state_q == S_IDLE);
  assign isMode  = newI.op inside {OP_WSEL, OP_TFRC, OP_ASCL, OP_XSCL, OP_BSET};
  assign isScan  = newI.op inside {OP_SCANW, OP_SCANB};
  assign am      = isScan ? AM_POSTIX : newI.amode;
  assign rel     = (isScan || am == AM_POSTIX) ? 1'b0 : newI.relP;
  // the mode alone picks word or byte; word-only ops ignore byte mode
  assign byteNew = byteMode_q && (forceCnt_q == 8'h00)
                   && (newI.op != OP_WORDONLY);

  // ****************************************************************
  // address arithmetic helpers
  // ****************************************************************
  // word location of a direct operand or pointer: base page or P window
  function automatic logic [14:0] wordLoc(input logic [15:0] pc, input instr_t i,
                                          input logic r);
    if (!r) return {BASE_PAGE_HI[6:0], i.disp};
    else if (i.back) return 15'(pc - 16'(i.disp));
    else return 15'(pc + 16'h0001 + 16'(i.disp));
  endfunction : wordLoc

  // 17-bit sum: carry out of bit15 and carry into bit15 give overflow
  function automatic logic [16:0] addSub(input logic [15:0] a, input logic [15:0] b,
                                         input logic sub);
    logic [15:0] bb;
    logic [16:0] s;
    logic [15:0] lo;
    bb = sub ? ~b : b;
    s  = {1'b0, a} + {1'b0, bb} + {16'h0000, sub};
    lo = {1'b0, a[14:0]} + {1'b0, bb[14:0]} + {15'h0000, sub};
    return {s[16] ^ lo[15], s[15:0]};
  endfunction : addSub

  logic [14:0] locNew;                   // pointer or direct word location
  logic [15:0] byteDirect;               // byte direct address
  assign locNew     = wordLoc(pc_q, newI, rel);
  assign byteDirect = newI.relP
                    ? {pc_q[14:0] + 15'h0001, 1'b0} + {7'h00, newI.back, newI.disp}
                    : {8'h00, newI.disp};

  // pointer decode on return
  logic [15:0] ptrAdd;                   // pointer plus index where asked
  logic        postIx;                   // instruction adds index after pointer
  assign postIx = (instr_q.amode == AM_POSTIX);
  assign ptrAdd = byteOp_q
                ? memRdata + (postIx ? x_q : 16'h0000)
                : {1'b0, 15'(memRdata[14:0] + (postIx ? x_q[14:0] : 15'h0000))};

  // byte operand, zero extended; bit0 clear picks the upper byte
  logic [15:0] opVal;
  assign opVal = !byteOp_q ? memRdata
               : (ea_q[0] ? {BYTE_ZERO, memRdata[7:0]}
                          : {BYTE_ZERO, memRdata[15:8]});

  logic [16:0] alu;                      // {overflow, sum}
  assign alu = addSub(acc_q, opVal, instr_q.op == OP_SUB);

  // ****************************************************************
  // sequencer and memory requests
  // ****************************************************************
  // one outstanding read at a time; a pointer chain can run without bound
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= S_IDLE;
      instr_q   <= instr_t'(16'h0000);
      byteOp_q  <= 1'b0;
      ea_q      <= 16'h0000;
      opnd_q    <= 16'h0000;
      memRead_q <= 1'b0;
      memAddr_q <= 15'h0000;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start && !isMode) begin
            instr_q  <= instr_t'({newI.op, newI.back, rel, am, newI.disp});
            byteOp_q <= byteNew;
            unique case (am)
              AM_DIRECT: begin
                // direct goes straight to the operand
                ea_q      <= byteNew ? byteDirect : {1'b0, locNew};
                memAddr_q <= byteNew ? byteDirect[15:1] : locNew;
                memRead_q <= 1'b1;
                state_q   <= S_OPND;
              end
              AM_INDEX: begin
                // index counts bytes in byte mode, words otherwise
                ea_q      <= byteNew ? x_q + 16'(newI.disp)
                                     : {1'b0, 15'(x_q + 16'(newI.disp))};
                memAddr_q <= byteNew ? 15'((x_q + 16'(newI.disp)) >> 1)
                                     : 15'(x_q + 16'(newI.disp));
                memRead_q <= 1'b1;
                state_q   <= S_OPND;
              end
              default: begin
                // indirect forms fetch a pointer first
                memAddr_q <= locNew;
                memRead_q <= 1'b1;
                state_q   <= S_PTR;
              end
            endcase
          end
        end
        S_PTR: begin
          if (memValid) begin
            if (!byteOp_q && memRdata[15]) begin
              memAddr_q <= memRdata[14:0];
            end else begin
              // byte pointers are never chained, all sixteen bits address
              ea_q      <= ptrAdd;
              memAddr_q <= byteOp_q ? ptrAdd[15:1] : ptrAdd[14:0];
              state_q   <= S_OPND;
            end
          end
        end
        S_OPND: begin
          if (memValid) begin
            opnd_q    <= opVal;
            memRead_q <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // word / byte mode state
  // ****************************************************************
  // the timed force leaves byteMode_q alone so the old mode comes back
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      byteMode_q <= 1'b0;
      forceCnt_q <= 8'h00;
    end else if (start) begin
      unique case (newI.op)
        OP_WSEL, OP_ASCL, OP_XSCL: begin
          byteMode_q <= 1'b0;
          forceCnt_q <= 8'h00;
        end
        OP_TFRC: forceCnt_q <= newI.disp;
        OP_BSET: begin
          byteMode_q <= 1'b1;
          if (forceCnt_q != 8'h00) forceCnt_q <= forceCnt_q - 8'h01;
        end
        default: if (forceCnt_q != 8'h00) forceCnt_q <= forceCnt_q - 8'h01;
      endcase
    end
  end

  // ****************************************************************
  // software registers and arithmetic
  // ****************************************************************
  // hardware result wins over a software write of the accumulator
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q  <= 16'h0000;
      x_q   <= 16'h0000;
      acc_q <= 16'h0000;
    end else begin
      if (acc_go && write && address == REG_PC)
        pc_q <= (pc_q & ~wmask) | (writedata[15:0] & wmask);
      if (acc_go && write && address == REG_XREG)
        x_q <= (x_q & ~wmask) | (writedata[15:0] & wmask);
      if (state_q == S_OPND && memValid && instr_q.op inside {OP_ADD, OP_SUB})
        acc_q <= alu[15:0];
      else if (acc_go && write && address == REG_ACC)
        acc_q <= (acc_q & ~wmask) | (writedata[15:0] & wmask);
    end
  end

  // overflow: a set in the clearing cycle wins
  logic ovfSet;
  assign ovfSet = state_q == S_OPND && memValid
                  && instr_q.op inside {OP_ADD, OP_SUB} && alu[16];
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) ovf_q <= 1'b0;
    else if (ovfSet) ovf_q <= 1'b1;
    else if (wrStat && byteenable[0] && writedata[STAT_OVF_BIT]) ovf_q <= 1'b0;
  end

  // ****************************************************************
  // avalon answer: one wait cycle, then data stands
  // ****************************************************************
  status_t stat;
  assign stat = '{forceCnt: forceCnt_q, rsvd: 4'h0, overflow: ovf_q,
                  byteEff: byteMode_q && forceCnt_q == 8'h00,
                  byteMode: byteMode_q, busy: state_q != S_IDLE};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((read | write) && wait_q);
      if (read && wait_q) begin
        // unmapped offsets read as zero
        unique case (address)
          REG_INSTR:  rdata_q <= {16'h0000, instr_q};
          REG_PC:     rdata_q <= {16'h0000, pc_q};
          REG_XREG:   rdata_q <= {16'h0000, x_q};
          REG_ACC:    rdata_q <= {16'h0000, acc_q};
          REG_STATUS: rdata_q <= {16'h0000, stat};
          REG_EADDR:  rdata_q <= {16'h0000, ea_q};
          REG_OPND:   rdata_q <= {16'h0000, opnd_q};
          default:    rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign memRead     = memRead_q;
  assign memAddr     = memAddr_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // mode control and timed force
  byte_set_a: assert property (start && newI.op == OP_BSET |=> byteMode_q)
    else $error("byte mode not entered");

  byte_rise_a: assert property ($rose(byteMode_q)
    |-> $past(start && newI.op == OP_BSET))
    else $error("byte mode entered without command");

  word_force_a: assert property (start && newI.op inside {OP_WSEL, OP_ASCL, OP_XSCL}
    |=> !byteMode_q && forceCnt_q == 8'h00)
    else $error("word mode not forced");

  timed_count_a: assert property (start && newI.op == OP_TFRC
    |=> forceCnt_q == $past(newI.disp))
    else $error("force count wrong");

  force_dec_a: assert property (start && forceCnt_q != 8'h00
    && !(newI.op inside {OP_WSEL, OP_ASCL, OP_XSCL, OP_TFRC})
    |=> forceCnt_q == $past(forceCnt_q) - 8'h01)
    else $error("force count not stepped");

  force_keeps_mode_a: assert property (start && newI.op == OP_TFRC
    |=> $stable(byteMode_q))
    else $error("saved mode disturbed");

  wordonly_mode_a: assert property (start && newI.op == OP_WORDONLY && !isMode
    |=> !byteOp_q)
    else $error("word-only op in byte mode");

  // address forming
  base_direct_a: assert property (start && !isMode && !isScan
    && newI.amode == AM_DIRECT && !newI.relP
    |=> ea_q == {8'h00, $past(newI.disp)})
    else $error("base page address wrong");

  word_index_a: assert property (start && !isMode && !isScan
    && newI.amode == AM_INDEX && !byteNew
    |=> ea_q == {1'b0, 15'($past(x_q) + {8'h00, $past(newI.disp)})})
    else $error("word indexed address wrong");

  byte_index_a: assert property (start && !isMode && !isScan
    && newI.amode == AM_INDEX && byteNew
    |=> ea_q == $past(x_q) + {8'h00, $past(newI.disp)})
    else $error("byte indexed address wrong");

  scan_postix_a: assert property (start && isScan
    |=> state_q == S_PTR && instr_q.amode == AM_POSTIX && !instr_q.relP)
    else $error("scan not postindexed");

  // pointer walk; a chain has no length limit, so each step is checked alone
  chain_follow_a: assert property (state_q == S_PTR && memValid && !byteOp_q
    && memRdata[15] |=> state_q == S_PTR && memAddr_q == $past(memRdata[14:0]))
    else $error("pointer chain not followed");

  word_ptr_a: assert property (state_q == S_PTR && memValid && !byteOp_q
    && !memRdata[15] |=> state_q == S_OPND && !ea_q[15])
    else $error("word pointer decoded wrong");

  byte_one_level_a: assert property (state_q == S_PTR && memValid && byteOp_q
    |=> state_q == S_OPND)
    else $error("byte pointer chained");

  byte_addr_a: assert property (state_q == S_PTR && memValid && byteOp_q
    |=> memAddr_q == ea_q[15:1])
    else $error("byte pointer split wrong");

  mem_hold_a: assert property (memRead && !memValid |=> memRead && $stable(memAddr))
    else $error("memory request dropped");

  // arithmetic and bus
  byte_zero_ext_a: assert property (state_q == S_OPND && memValid && byteOp_q
    |=> opnd_q[15:8] == 8'h00)
    else $error("byte operand not zero extended");

  ovf_set_a: assert property (ovfSet |=> ovf_q)
    else $error("overflow lost");

  ovf_sticky_a: assert property (ovf_q
    && !(wrStat && byteenable[0] && writedata[STAT_OVF_BIT]) |=> ovf_q)
    else $error("overflow dropped");

  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");

  // scenarios worth seeing
  chain_c:  cover property (state_q == S_PTR && memValid && memRdata[15] && !byteOp_q);
  byte_c:   cover property (state_q == S_OPND && memValid && byteOp_q);
  ovf_c:    cover property (ovfSet);
  force_c:  cover property (start && newI.op == OP_TFRC ##1 forceCnt_q != 8'h00);
  postix_c: cover property (start && am == AM_POSTIX && byteNew);

endmodule : memory_ref_address_unit

// >>> logic/mref_pkg.sv
// Overview of operation
// - reset leaves word mode, sixteen-bit operands
// - word, accum-scaled, index-scaled ops force word mode
// - timed force holds word mode for N instructions
// - word pointer: low fifteen address, top bit indirect
// - word direct: base page or P window
// - word indirect chains while pointer top bit set
// - word pointer from scratchpad or P window
// - word indexed: signed index plus offset 0-255
// - word postindexed: chain, then add index
// - scans always postindexed through base-page pointer
// - set-byte-mode enters persistent eight-bit byte mode
// - same opcodes; mode alone picks address kind
// - byte pointer: word address high, bit0 byte
// - byte indirect is exactly one pointer level
// - byte operands sit right-justified in register
// - listed word-only instructions ignore byte mode
// - byte direct: first 256 bytes or 512 following
// - byte pointer from scratchpad or P window
// - byte indexed: index plus base 0-255
// - byte postindexed: scratchpad pointer plus index
// - add sums operand into accumulator, sets overflow
// - subtract takes operand from accumulator, sets overflow
// - base page is lowest 256 words
// - byte operand zero-extended before arithmetic
// - overflow when carry into and out of bit15 differ
package mref_pkg;

  // ****************************************************************
  // register map, byte offsets on the avalon slave
  // ****************************************************************
  localparam logic [4:0] REG_INSTR  = 5'h00;  // write starts an instruction
  localparam logic [4:0] REG_PC     = 5'h04;  // program counter
  localparam logic [4:0] REG_XREG   = 5'h08;  // index register
  localparam logic [4:0] REG_ACC    = 5'h0C;  // accumulator
  localparam logic [4:0] REG_STATUS = 5'h10;  // state, write 1 to bit3 clears overflow
  localparam logic [4:0] REG_EADDR  = 5'h14;  // last effective address
  localparam logic [4:0] REG_OPND   = 5'h18;  // last operand fetched

  // ****************************************************************
  // field positions and constants
  // ****************************************************************
  localparam int         STAT_OVF_BIT = 3;      // overflow clear bit in status
  localparam logic [7:0] BASE_PAGE_HI = 8'h00;  // base page: lowest 256 words
  localparam logic [7:0] BYTE_ZERO    = 8'h00;  // upper half of a byte operand

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_MEMREF   = 4'h0,  // plain memory reference, operand fetch only
    OP_ADD      = 4'h1,
    OP_SUB      = 4'h2,
    OP_WSEL     = 4'h3,  // select_word_mode_op
    OP_TFRC     = 4'h4,  // timed_word_force_op, count in disp
    OP_ASCL     = 4'h5,  // accum_scaled_mode_op
    OP_XSCL     = 4'h6,  // index_scaled_mode_op
    OP_BSET     = 4'h7,  // set_byte_mode_op
    OP_SCANW    = 4'h8,  // scan_word_op
    OP_SCANB    = 4'h9,  // scan_byte_op
    OP_WORDONLY = 4'hA   // increment_skip_op, jump_store_op and the rest
  } op_t;

  typedef enum logic [1:0] {
    AM_DIRECT = 2'h0,
    AM_IND    = 2'h1,
    AM_INDEX  = 2'h2,
    AM_POSTIX = 2'h3
  } amode_t;

  typedef struct packed {
    op_t        op;     // [15:12]
    logic       back;   // [11] P-relative backwards, byte direct offset bit 8
    logic       relP;   // [10] P-relative rather than base page
    amode_t     amode;  // [9:8]
    logic [7:0] disp;   // [7:0]
  } instr_t;

  typedef struct packed {
    logic [7:0] forceCnt;  // [15:8]
    logic [3:0] rsvd;      // [7:4] read as zero
    logic       overflow;  // [3]
    logic       byteEff;   // [2] byte mode in force now
    logic       byteMode;  // [1] established mode
    logic       busy;      // [0]
  } status_t;

endpackage : mref_pkg

// >>> bench/mem_model.sv
`timescale 1ns/100ps
// ****************************************************************
// main memory partner, word addressed, variable latency
// ****************************************************************
module mem_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // read port
  input  wire logic        memRead,
  input  wire logic [14:0] memAddr,
  output logic      [15:0] memRdata,
  output logic             memValid
);
  logic [15:0] mem [0:32767];  // loaded by the bench
  logic [1:0]  waitCnt;        // cycles waited on this access
  logic [1:0]  slow;           // latency of this access, rotates 0..3

  // answer after 0..3 idle cycles; data lines toggle when not valid so
  // a design that samples stale data cannot pass by luck
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memValid <= 1'b0;
      waitCnt  <= 2'h0;
      slow     <= 2'h0;
      memRdata <= 16'hA5A5;
    end else if (memValid) begin
      memValid <= 1'b0;
      memRdata <= ~memRdata;
      waitCnt  <= 2'h0;
      slow     <= slow + 2'h1;
    end else if (memRead && (waitCnt >= slow)) begin
      memValid <= 1'b1;
      memRdata <= mem[memAddr];
    end else begin
      waitCnt  <= memRead ? waitCnt + 2'h1 : 2'h0;
      memRdata <= ~memRdata;
    end
  end
endmodule : mem_model

// >>> bench/memory_ref_address_unit_tb.sv
`timescale 1ns/100ps
module memory_ref_address_unit_tb;
  import mref_pkg::*;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        mclk, rst_b;        // clock, reset
  logic [4:0]  address;            // avalon request
  logic        read, write;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        waitrequest;
  logic        memRead, memValid;  // memory port
  logic [14:0] memAddr;
  logic [15:0] memRdata;
  logic [15:0] rd;                 // last read value
  int          err_total, num_checks;
  op_t         modeOps [3] = '{OP_WSEL, OP_ASCL, OP_XSCL};

  memory_ref_address_unit memory_ref_address_unit_i (.mclk(mclk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .memRead(memRead), .memAddr(memAddr), .memRdata(memRdata), .memValid(memValid));
  mem_model mem_model_i (.mclk(mclk), .rst_b(rst_b), .memRead(memRead),
    .memAddr(memAddr), .memRdata(memRdata), .memValid(memValid));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] mk(op_t o, logic b, logic r, amode_t a, logic [7:0] d);
    return {o, b, r, a, d};
  endfunction : mk
  // fill pattern of plain memory words
  function automatic logic [15:0] w(logic [15:0] a);
    return a ^ 16'hA500;
  endfunction : w
  task results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // one avalon transfer; request stands until a rising edge sees waitrequest low
  task busCycle(input logic [4:0] a, input logic wr, input logic [15:0] d,
                output logic [15:0] q);
    int n;
    @(posedge mclk);
    address <= a; writedata <= {16'h0000, d}; write <= wr; read <= ~wr;
    n = 0;
    do begin @(posedge mclk); n++; end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin err_total++; results(); end
    q = readdata[15:0];
    read <= 1'b0; write <= 1'b0;
  endtask : busCycle
  task chk2(input string nm, input logic [4:0] a, input logic [15:0] e);
    busCycle(a, 1'b0, 16'h0000, rd);
    `CHK(nm, e, rd)
  endtask : chk2
  // start an instruction and poll busy, bounded
  task exec(input logic [15:0] ins);
    int n;
    busCycle(REG_INSTR, 1'b1, ins, rd);
    n = 0;
    do begin busCycle(REG_STATUS, 1'b0, 16'h0000, rd); n++; end
    while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200) begin err_total++; results(); end
  endtask : exec
  task ea(input logic [15:0] ins, input logic [15:0] e, input logic [15:0] o);
    exec(ins);
    chk2("eaddr", REG_EADDR, e);
    chk2("opnd", REG_OPND, o);
  endtask : ea
  task wr(input logic [4:0] a, input logic [15:0] d);
    busCycle(a, 1'b1, d, rd);
  endtask : wr
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0; address = 5'h00; read = 1'b0; write = 1'b0;
    writedata = 32'h0; byteenable = 4'hF; err_total = 0; num_checks = 0;
    for (int i = 0; i < 16'h200; i++) mem_model_i.mem[i] = w(16'(i));
    mem_model_i.mem[16'h11] = 16'h0001;  // arithmetic operand
    mem_model_i.mem[16'h20] = 16'h8030;  // chained pointer
    mem_model_i.mem[16'h30] = 16'h0050;  // final pointer
    mem_model_i.mem[16'h22] = 16'h80A0;  // byte pointer, top bit set
    mem_model_i.mem[16'h4050] = 16'h12AB;
    mem_model_i.mem[16'h4052] = 16'h34CD;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    chk2("status", REG_STATUS, 16'h0000);
    chk2("unmapped", 5'h1C, 16'h0000);
    wr(REG_PC, 16'h0040);
    ea(mk(OP_MEMREF, 0, 0, AM_DIRECT, 8'h10), 16'h0010, w(16'h10));
    ea(mk(OP_MEMREF, 0, 1, AM_DIRECT, 8'hFF), 16'h0140, w(16'h140));
    ea(mk(OP_MEMREF, 1, 1, AM_DIRECT, 8'h00), 16'h0040, w(16'h40));
    ea(mk(OP_MEMREF, 0, 0, AM_IND, 8'h20), 16'h0050, w(16'h50));
    wr(REG_XREG, 16'hFFFE);
    ea(mk(OP_MEMREF, 0, 0, AM_INDEX, 8'h05), 16'h0003, w(16'h3));
    wr(REG_XREG, 16'h0003);
    ea(mk(OP_MEMREF, 0, 0, AM_INDEX, 8'hFF), 16'h0102, w(16'h102));
    ea(mk(OP_MEMREF, 0, 0, AM_POSTIX, 8'h20), 16'h0053, w(16'h53));
    ea(mk(OP_SCANW, 0, 0, AM_DIRECT, 8'h20), 16'h0053, w(16'h53));
    // signed overflow both ways, sticky until cleared
    wr(REG_ACC, 16'h7FFF);
    ea(mk(OP_ADD, 0, 0, AM_DIRECT, 8'h11), 16'h0011, 16'h0001);
    chk2("acc", REG_ACC, 16'h8000);
    chk2("status", REG_STATUS, 16'h0008);
    wr(REG_STATUS, 16'h0008);
    wr(REG_ACC, 16'h0002);
    exec(mk(OP_ADD, 0, 0, AM_DIRECT, 8'h11));
    chk2("acc", REG_ACC, 16'h0003);
    chk2("status", REG_STATUS, 16'h0000);
    wr(REG_ACC, 16'h8000);
    exec(mk(OP_SUB, 0, 0, AM_DIRECT, 8'h11));
    chk2("acc", REG_ACC, 16'h7FFF);
    chk2("status", REG_STATUS, 16'h0008);
    wr(REG_STATUS, 16'h0008);
    // byte mode, same opcodes
    exec(mk(OP_BSET, 0, 0, AM_DIRECT, 8'h00));
    chk2("status", REG_STATUS, 16'h0006);
    ea(mk(OP_MEMREF, 0, 0, AM_DIRECT, 8'h21), 16'h0021, 16'h0010);
    ea(mk(OP_MEMREF, 1, 1, AM_DIRECT, 8'hFF), 16'h0281, 16'h0040);
    ea(mk(OP_MEMREF, 0, 0, AM_IND, 8'h22), 16'h80A0, 16'h0012);
    wr(REG_XREG, 16'h0005);
    ea(mk(OP_MEMREF, 0, 0, AM_INDEX, 8'h10), 16'h0015, 16'h000A);
    ea(mk(OP_MEMREF, 0, 0, AM_POSTIX, 8'h22), 16'h80A5, 16'h00CD);
    ea(mk(OP_SCANB, 0, 0, AM_DIRECT, 8'h22), 16'h80A5, 16'h00CD);
    wr(REG_ACC, 16'h00F0);
    exec(mk(OP_ADD, 0, 0, AM_DIRECT, 8'h21));
    chk2("acc", REG_ACC, 16'h0100);
    exec(mk(OP_SUB, 0, 0, AM_DIRECT, 8'h21));
    chk2("acc", REG_ACC, 16'h00F0);
    ea(mk(OP_WORDONLY, 0, 0, AM_DIRECT, 8'h10), 16'h0010, w(16'h10));
    // timed force for two instructions, then byte mode again
    exec(mk(OP_TFRC, 0, 0, AM_DIRECT, 8'h02));
    chk2("status", REG_STATUS, 16'h0202);
    ea(mk(OP_MEMREF, 0, 0, AM_DIRECT, 8'h21), 16'h0021, w(16'h21));
    ea(mk(OP_MEMREF, 0, 0, AM_DIRECT, 8'h21), 16'h0021, w(16'h21));
    ea(mk(OP_MEMREF, 0, 0, AM_DIRECT, 8'h21), 16'h0021, 16'h0010);
    // every unconditional word mode op cancels byte mode
    foreach (modeOps[i]) begin
      exec(mk(OP_BSET, 0, 0, AM_DIRECT, 8'h00));
      exec(mk(modeOps[i], 0, 0, AM_DIRECT, 8'h00));
      chk2("status", REG_STATUS, 16'h0000);
    end
    ea(mk(OP_MEMREF, 0, 0, AM_DIRECT, 8'h21), 16'h0021, w(16'h21));
    results();
  end
endmodule : memory_ref_address_unit_tb
